// ---- rtl/shcd_defines.svh ----
// Constants of the serial host command decoder: codes, fields, offsets.
// Assumes inclusion by both link ends and by the bench.
`ifndef SHCD_DEFINES_SVH
`define SHCD_DEFINES_SVH

// Command codes
`define SHCD_CODE_MEM_READ 8'h08
`define SHCD_CODE_MEM_WRITE 8'h18
`define SHCD_CODE_CTRL_READBACK 8'h68
`define SHCD_CODE_CTRL_WRITE 8'h78
`define SHCD_CODE_TUNNEL_REQUEST 8'h28
`define SHCD_CODE_TUNNEL_ANSWER 8'h38

// Result codes in status bits 3..0
`define SHCD_RES_NONE 4'h0
`define SHCD_RES_NORMAL 4'h5
`define SHCD_RES_BUSY 4'h7
`define SHCD_RES_UNKNOWN 4'h8
`define SHCD_RES_TUNNEL_ERR 4'h9
`define SHCD_RES_PARAM_ERR 4'hA
`define SHCD_RES_HOST_BUSY 4'hF

// Length limits, in bytes
`define SHCD_READ_LEN_MIN 8'h01
`define SHCD_READ_LEN_MAX 8'hFE
`define SHCD_WRITE_LEN_MIN 8'h01
`define SHCD_WRITE_LEN_MAX 8'hFB

// Command byte positions
`define SHCD_POS_ADDR_HI 9'h001
`define SHCD_POS_ADDR_LO 9'h002
`define SHCD_POS_LEN 9'h003
`define SHCD_HEADER_BYTES 9'h004

// Control byte fields
`define SHCD_CTRL_SELF_RESET_BIT 0
`define SHCD_CTRL_RESERVED_ONE 1'b1
`define SHCD_CTRL_RESET 5'h00
`define SHCD_FILL_BYTE 8'hFF

// Host APB register offsets
`define SHCD_REG_TX 8'h00
`define SHCD_REG_RX 8'h04
`define SHCD_REG_END 8'h08
`define SHCD_REG_STAT 8'h0C
`define SHCD_TX_STOP_BIT 8
`define SHCD_RX_LAST_BIT 8

`endif

// ---- rtl/shcd_pkg.sv ----
// Types shared by both ends of the serial host command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package shcd_pkg;
  typedef enum logic [1:0] {DS_COLLECT, DS_ANSWER} shcd_dev_state_t;
  typedef enum logic [2:0] {HS_IDLE, HS_STOP, HS_WAIT, HS_DONE} shcd_host_state_t;
  typedef logic [7:0] shcd_byte_t;
endpackage : shcd_pkg

// ---- rtl/shcd_link_if.sv ----
// Byte-level link between host controller and command decoder.
// Assumes one clock shared by both ends; the bench instantiates it.
interface shcd_link_if;
  import shcd_pkg::*;
  logic wr_valid; // Host byte strobe (slave reception)
  shcd_byte_t wr_data;
  logic wr_end; // Frame end after written bytes
  logic rd_req; // Request for one response byte
  logic rsp_valid; // Answer strobe, one cycle after rd_req
  shcd_byte_t rsp_data;
  logic rsp_last;
  logic rd_end; // Host closes a reading frame
  modport device (input wr_valid, wr_data, wr_end, rd_req, rd_end, output rsp_valid, rsp_data, rsp_last);
  modport host (output wr_valid, wr_data, wr_end, rd_req, rd_end, input rsp_valid, rsp_data, rsp_last);
endinterface : shcd_link_if

// ---- rtl/shcd_device.sv ----
// Device end: decodes host commands and answers with status and data.
// Assumes the host keeps to the link handshake and one clock pclk.
`include "shcd_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RL1] - Busy radio: read, write, poll answer 0x7
// [RL2] - Busy radio: readback normal, control write 0xA
// [RL3] - Tunnel request or answer returns 0x9
// [RL4] - Code 0x78 stores control settings
// [RL5] - Status poll has no command code
// [RL6] - Read: 0x08, address high first, length
// [RL7] - Host keeps read length 1 to 254
// [RL8] - Read answer: status then data, or status alone
// [RL9] - Write: 0x18, address, length, data; status answer
// [RL10] - Host keeps write length 1 to 251
// [RL11] - Readback 0x68 returns status plus control byte
// [RL12] - Readback bits 7..3 echo last written settings
// [RL13] - Readback bit 2 always one
// [RL14] - Readback bit 1 is enable check error
// [RL15] - Readback bit 0 is check character error
// [RL16] - Status: four event flags, then result code
// [RL17] - Read without command is a status poll
// [RL18] - Unknown code gives result 0x8
// [RL19] - Direction picks command intake or response
// [RL20] - Bad address or length: parameter error, no data
// [RL21] - Response held until read, then new command
module shcd_device #(
  parameter int MEM_BYTES = 1024
) (
  input wire logic pclk,
  input wire logic presetn,
  shcd_link_if.device link,
  input wire logic radio_busy,
  input wire logic radio_write_event,
  input wire logic radio_read_event,
  input wire logic radio_transmit_event,
  input wire logic field_detect_event,
  input wire logic config_enable_check,
  input wire logic block_check_character,
  output logic [3:0] irq_mask,
  output logic radio_stop,
  output logic self_reset_req
);
  import shcd_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);

  shcd_dev_state_t state;
  shcd_byte_t mem [MEM_BYTES];
  shcd_byte_t code_q;
  logic [15:0] addr_q;
  shcd_byte_t len_q;
  logic [8:0] rx_cnt;
  logic [8:0] tx_idx;
  logic [8:0] tx_total;
  logic [3:0] result_q;
  logic [3:0] flags_q;
  logic [4:0] ctrl_q;
  logic reset_armed;

  //////////////////////////////////////////////////////////////////////////////
  // Decode of the arriving stream
  logic take_byte;
  logic first_byte;
  logic cmd_complete;
  logic frame_done;
  logic poll_now;
  logic answer_now;
  logic answer_over;
  logic [16:0] end_addr;
  logic range_ok;
  logic len_ok;
  logic [3:0] len_result;
  logic [3:0] end_result;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  shcd_byte_t readback_byte;
  logic [8:0] data_pos;

  // Bytes only count while no response waits to be read
  assign take_byte = link.wr_valid && (state == DS_COLLECT); // [RL19]
  assign first_byte = take_byte && (rx_cnt == 9'h000);
  assign data_pos = rx_cnt - `SHCD_HEADER_BYTES;

  // Command length known from code, and length byte for writes
  always_comb begin
    case (code_q)
      `SHCD_CODE_MEM_READ: cmd_complete = (rx_cnt >= `SHCD_HEADER_BYTES); // [RL6]
      `SHCD_CODE_MEM_WRITE: cmd_complete = (rx_cnt >= `SHCD_HEADER_BYTES)
        && (rx_cnt >= `SHCD_HEADER_BYTES + {1'b0, len_q}); // [RL9]
      `SHCD_CODE_CTRL_WRITE: cmd_complete = (rx_cnt >= 9'h002); // [RL4]
      default: cmd_complete = (rx_cnt >= 9'h001);
    endcase
  end

  // Frame end counts only once the command is whole; divided frames keep going
  assign frame_done = link.wr_end && (state == DS_COLLECT) && cmd_complete && (rx_cnt != 9'h000);
  // Read request with no command pending is a status poll
  assign poll_now = link.rd_req && (state == DS_COLLECT); // [RL5] [RL17]
  assign answer_now = link.rd_req && (state == DS_ANSWER); // [RL19]
  assign answer_over = link.rd_end && (state == DS_ANSWER) && (tx_idx >= tx_total); // [RL21]

  // Address window check, length byte arriving now
  assign end_addr = {1'b0, addr_q} + {9'h000, link.wr_data};
  assign range_ok = (end_addr <= 17'(MEM_BYTES)); // [RL20]
  always_comb begin
    if (code_q == `SHCD_CODE_MEM_READ) begin
      len_ok = (link.wr_data >= `SHCD_READ_LEN_MIN) && (link.wr_data <= `SHCD_READ_LEN_MAX);
    end else begin
      len_ok = (link.wr_data >= `SHCD_WRITE_LEN_MIN) && (link.wr_data <= `SHCD_WRITE_LEN_MAX);
    end
  end

  // Busy outranks parameter checks for memory access
  always_comb begin
    if (radio_busy) begin
      len_result = `SHCD_RES_BUSY; // [RL1]
    end else if (!len_ok || !range_ok) begin
      len_result = `SHCD_RES_PARAM_ERR; // [RL20]
    end else begin
      len_result = `SHCD_RES_NORMAL;
    end
  end

  // Result fixed when the frame closes
  always_comb begin
    case (code_q)
      `SHCD_CODE_MEM_READ,
      `SHCD_CODE_MEM_WRITE: end_result = result_q;
      `SHCD_CODE_CTRL_READBACK: end_result = `SHCD_RES_NORMAL; // [RL2] [RL11]
      `SHCD_CODE_CTRL_WRITE: end_result = radio_busy ? `SHCD_RES_PARAM_ERR : `SHCD_RES_NORMAL; // [RL2]
      `SHCD_CODE_TUNNEL_REQUEST,
      `SHCD_CODE_TUNNEL_ANSWER: end_result = `SHCD_RES_TUNNEL_ERR; // [RL3]
      default: end_result = `SHCD_RES_UNKNOWN; // [RL18]
    endcase
  end

  // Control byte as seen by the host
  assign readback_byte = {ctrl_q, `SHCD_CTRL_RESERVED_ONE, // [RL12] [RL13]
                          config_enable_check, block_check_character}; // [RL14] [RL15]

  //////////////////////////////////////////////////////////////////////////////
  // Command intake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 8'h00;
      addr_q <= 16'h0000;
      len_q <= 8'h00;
      rx_cnt <= 9'h000;
    end else if (answer_over) begin
      rx_cnt <= 9'h000;
    end else if (take_byte) begin
      rx_cnt <= rx_cnt + 9'h001;
      if (first_byte) begin
        code_q <= link.wr_data;
      end
      if (rx_cnt == `SHCD_POS_ADDR_HI) begin
        addr_q[15:8] <= link.wr_data; // [RL6] [RL9]
      end
      if (rx_cnt == `SHCD_POS_ADDR_LO) begin
        addr_q[7:0] <= link.wr_data;
      end
      if (rx_cnt == `SHCD_POS_LEN) begin
        len_q <= link.wr_data;
      end
    end
  end

  // Result code: judged at the length byte, then at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= `SHCD_RES_NONE;
    end else if (answer_over) begin
      result_q <= `SHCD_RES_NONE;
    end else if (take_byte && (rx_cnt == `SHCD_POS_LEN)) begin
      result_q <= len_result;
    end else if (frame_done) begin
      result_q <= end_result;
    end
  end

  // Memory writes only after a clean check; bad ones move no data
  always_ff @(posedge pclk) begin
    if (take_byte && (code_q == `SHCD_CODE_MEM_WRITE) && (rx_cnt >= `SHCD_HEADER_BYTES)
        && (data_pos < {1'b0, len_q}) && (result_q == `SHCD_RES_NORMAL)) begin
      mem[AW'(addr_q + {7'h00, data_pos})] <= link.wr_data; // [RL9] [RL20]
    end
  end

  // Control settings from the control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SHCD_CTRL_RESET;
      reset_armed <= 1'b0;
    end else if (frame_done && (code_q == `SHCD_CODE_CTRL_WRITE)) begin
      // Busy at frame end refuses the write, so nothing is stored or armed
      if (radio_busy) begin
        reset_armed <= 1'b0;
      end else begin
        ctrl_q <= addr_q[15:11]; // [RL4]
      end
    end else if (take_byte && (code_q == `SHCD_CODE_CTRL_WRITE) && (rx_cnt == 9'h001)) begin
      reset_armed <= link.wr_data[`SHCD_CTRL_SELF_RESET_BIT] && !radio_busy;
    end else if (answer_over) begin
      reset_armed <= 1'b0;
    end
  end

  // Second byte of a control write lands in the address-high slot
  assign irq_mask = ctrl_q[4:1];
  assign radio_stop = ctrl_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // Pending event flags; a set in the clearing cycle wins
  assign flag_set = {radio_write_event, radio_read_event, radio_transmit_event, field_detect_event}
                    & ~ctrl_q[4:1];
  assign flag_clr = ((poll_now || answer_now) && (tx_idx == 9'h000)) ? 4'hF : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set; // [RL16]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answer phase state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DS_COLLECT;
      tx_total <= 9'h000;
    end else if (frame_done) begin
      state <= DS_ANSWER;
      if ((code_q == `SHCD_CODE_MEM_READ) && (end_result == `SHCD_RES_NORMAL)) begin
        tx_total <= {1'b0, len_q} + 9'h001; // [RL8]
      end else if (end_result == `SHCD_RES_NORMAL && code_q == `SHCD_CODE_CTRL_READBACK) begin
        tx_total <= 9'h002; // [RL11]
      end else begin
        tx_total <= 9'h001; // [RL8] [RL9]
      end
    end else if (answer_over) begin
      state <= DS_COLLECT; // [RL21]
    end
  end

  // Response byte index, kept across divided reading frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_idx <= 9'h000;
    end else if (answer_over || frame_done) begin
      tx_idx <= 9'h000;
    end else if (answer_now && (tx_idx < tx_total)) begin
      tx_idx <= tx_idx + 9'h001;
    end
  end

  // Response bytes: status first, then data; fill bytes past the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data <= 8'h00;
      link.rsp_last <= 1'b0;
    end else begin
      link.rsp_valid <= poll_now || answer_now;
      if (poll_now) begin
        // Half-received command reports host busy, otherwise idle or busy
        link.rsp_data <= {flags_q, (rx_cnt != 9'h000) ? `SHCD_RES_HOST_BUSY :
                          radio_busy ? `SHCD_RES_BUSY : `SHCD_RES_NONE}; // [RL1] [RL16] [RL17]
        link.rsp_last <= 1'b1;
      end else if (answer_now) begin
        link.rsp_last <= (tx_idx + 9'h001 >= tx_total);
        if (tx_idx == 9'h000) begin
          link.rsp_data <= {flags_q, result_q}; // [RL16]
        end else if (tx_idx >= tx_total) begin
          link.rsp_data <= `SHCD_FILL_BYTE;
          link.rsp_last <= 1'b1;
        end else if (code_q == `SHCD_CODE_CTRL_READBACK) begin
          link.rsp_data <= readback_byte; // [RL11]
        end else begin
          link.rsp_data <= mem[AW'(addr_q + {7'h00, tx_idx} - 16'h0001)]; // [RL8]
        end
      end
    end
  end

  // Self reset request only after its answer is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_reset_req <= 1'b0;
    end else begin
      self_reset_req <= answer_over && reset_armed;
    end
  end

endmodule : shcd_device

// ---- rtl/shcd_host.sv ----
// Host end: APB slave whose accesses become link bytes and requests.
// Assumes an APB master on pclk and the device on the same clock.
`include "shcd_defines.svh"

module shcd_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  shcd_link_if.host link
);
  import shcd_pkg::*;

  shcd_host_state_t state;
  logic err_q;
  logic refused;
  logic [2:0] tx_idx;
  shcd_byte_t code_q;
  logic access;
  logic len_bad;

  assign access = psel && penable && (state == HS_IDLE);
  assign pready = (state == HS_DONE);
  assign pslverr = pready && err_q;

  // Length byte checked before it leaves; bad lengths never reach the link
  always_comb begin
    len_bad = 1'b0;
    if (tx_idx == 3'(`SHCD_POS_LEN)) begin
      if (code_q == `SHCD_CODE_MEM_READ) begin
        len_bad = (pwdata[7:0] < `SHCD_READ_LEN_MIN) || (pwdata[7:0] > `SHCD_READ_LEN_MAX); // [RL7]
      end else if (code_q == `SHCD_CODE_MEM_WRITE) begin
        len_bad = (pwdata[7:0] < `SHCD_WRITE_LEN_MIN) || (pwdata[7:0] > `SHCD_WRITE_LEN_MAX); // [RL10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
      err_q <= 1'b0;
      prdata <= 32'h0000_0000;
      link.wr_valid <= 1'b0;
      link.wr_data <= 8'h00;
      link.wr_end <= 1'b0;
      link.rd_req <= 1'b0;
      link.rd_end <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          err_q <= 1'b0;
          prdata <= 32'h0000_0000;
          if (access && pwrite && paddr == `SHCD_REG_TX) begin
            if (len_bad) begin
              err_q <= 1'b1;
              state <= HS_DONE;
            end else begin
              link.wr_valid <= 1'b1; // [RL6] [RL9]
              link.wr_data <= pwdata[7:0];
              state <= pwdata[`SHCD_TX_STOP_BIT] ? HS_STOP : HS_DONE;
            end
          end else if (access && !pwrite && paddr == `SHCD_REG_RX) begin
            link.rd_req <= 1'b1;
            state <= HS_WAIT;
          end else if (access && pwrite && paddr == `SHCD_REG_END) begin
            link.rd_end <= 1'b1;
            state <= HS_DONE;
          end else if (access && !pwrite && paddr == `SHCD_REG_STAT) begin
            prdata <= {31'h0000_0000, refused};
            state <= HS_DONE;
          end else if (access) begin
            err_q <= 1'b1; // Unmapped or wrong direction
            state <= HS_DONE;
          end
        end
        HS_STOP: begin
          link.wr_valid <= 1'b0;
          link.wr_end <= 1'b1;
          state <= HS_DONE;
        end
        HS_WAIT: begin
          link.rd_req <= 1'b0;
          if (link.rsp_valid) begin
            prdata <= {23'h000000, link.rsp_last, link.rsp_data};
            state <= HS_DONE;
          end
        end
        HS_DONE: begin
          link.wr_valid <= 1'b0;
          link.wr_end <= 1'b0;
          link.rd_end <= 1'b0;
          state <= HS_IDLE;
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // Byte position within a command, reset when an answer closes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_idx <= 3'h0;
      code_q <= 8'h00;
    end else if (access && pwrite && paddr == `SHCD_REG_END) begin
      tx_idx <= 3'h0;
    end else if (access && pwrite && paddr == `SHCD_REG_TX && !len_bad) begin
      if (tx_idx == 3'h0) begin
        code_q <= pwdata[7:0];
      end
      if (tx_idx != 3'h7) begin
        tx_idx <= tx_idx + 3'h1;
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over the clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
    end else if (access && pwrite && paddr == `SHCD_REG_TX && len_bad) begin
      refused <= 1'b1;
    end else if (access && pwrite && paddr == `SHCD_REG_STAT) begin
      refused <= 1'b0;
    end
  end

endmodule : shcd_host

// ---- verification/shcd_link_assertions.sv ----
// Checker of the byte link between host controller and command decoder.
// Assumes the bench instantiates it beside the link interface.
`include "shcd_defines.svh"

module shcd_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_valid,
  input wire shcd_pkg::shcd_byte_t wr_data,
  input wire logic wr_end,
  input wire logic rd_req,
  input wire logic rsp_valid,
  input wire shcd_pkg::shcd_byte_t rsp_data,
  input wire logic rsp_last,
  input wire logic rd_end
);
  import shcd_pkg::*;
  logic at_start;
  shcd_byte_t code;
  logic [7:0] rcnt;
  logic first;
  logic known;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////
  // Code byte of the frame; a closed answer rearms capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      at_start <= 1'b1;
      code <= 8'h00;
    end else if (rd_end) begin
      at_start <= 1'b1;
    end else if (wr_valid && at_start) begin
      at_start <= 1'b0;
      code <= wr_data;
    end
  end

  // Answer bytes since the reading frame was closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt <= 8'h00;
    end else if (rd_end) begin
      rcnt <= 8'h00;
    end else if (rsp_valid) begin
      rcnt <= rcnt + 8'h01;
    end
  end

  // Polls carry no code, so only command answers are judged here
  assign first = rsp_valid && !at_start && (rcnt == 8'h00);
  assign known = code inside {`SHCD_CODE_MEM_READ, `SHCD_CODE_MEM_WRITE, `SHCD_CODE_CTRL_READBACK,
    `SHCD_CODE_CTRL_WRITE, `SHCD_CODE_TUNNEL_REQUEST, `SHCD_CODE_TUNNEL_ANSWER};

  ////////////////////////////////////////////////////////////
  property p_rsp_after_req;
    rd_req |=> rsp_valid;
  endproperty
  a_rsp_after_req: assert property (p_rsp_after_req) else $error("no answer one cycle after request");
  property p_rsp_needs_req;
    rsp_valid |-> $past(rd_req);
  endproperty
  a_rsp_needs_req: assert property (p_rsp_needs_req) else $error("answer without request");
  property p_req_spacing;
    rd_req |=> !rd_req [*3];
  endproperty
  a_req_spacing: assert property (p_req_spacing) else $error("byte requests too close");
  property p_byte_spacing;
    wr_valid |=> !wr_valid [*3];
  endproperty
  a_byte_spacing: assert property (p_byte_spacing) else $error("command bytes too close");
  property p_stop_after_byte;
    wr_end |-> !wr_valid && !rd_req && $past(wr_valid);
  endproperty
  a_stop_after_byte: assert property (p_stop_after_byte) else $error("frame stop misplaced");
  property p_tunnel;
    first && (code == `SHCD_CODE_TUNNEL_REQUEST || code == `SHCD_CODE_TUNNEL_ANSWER) |-> rsp_data[3:0] == 4'h9;
  endproperty
  a_tunnel: assert property (p_tunnel) else $error("tunnel code result wrong");
  property p_unknown;
    first && !known |-> rsp_data[3:0] == 4'h8 && rsp_last;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code result wrong");
  property p_readback_status;
    first && code == `SHCD_CODE_CTRL_READBACK |-> rsp_data[3:0] == 4'h5 && !rsp_last;
  endproperty
  a_readback_status: assert property (p_readback_status) else $error("readback status wrong");
  property p_readback_bit2;
    rsp_valid && !at_start && rcnt == 8'h01 && code == `SHCD_CODE_CTRL_READBACK |-> rsp_data[2] && rsp_last;
  endproperty
  a_readback_bit2: assert property (p_readback_bit2) else $error("readback reserved bit low");
  property p_read_err_alone;
    first && code == `SHCD_CODE_MEM_READ && rsp_data[3:0] != 4'h5 |-> rsp_last;
  endproperty
  a_read_err_alone: assert property (p_read_err_alone) else $error("data after failed read status");
  property p_write_single;
    first && code == `SHCD_CODE_MEM_WRITE |-> rsp_last;
  endproperty
  a_write_single: assert property (p_write_single) else $error("write answer longer than status");
endmodule : shcd_link_assertions

// ---- verification/serial_host_command_decoder_tb.sv ----
// Bench joining host controller and command decoder over the link.
// Assumes the design files and the link checker are compiled first.
`include "shcd_defines.svh"

module serial_host_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic radio_busy, cfg_err, bcc_err, radio_stop, self_reset_req;
  logic [3:0] ev, irq_mask;
  logic [11:0] tbl [4];
  int bad_count, cmp_count, srst_count, i;
  shcd_link_if u_shcd_link_if ();

  shcd_host u_shcd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_shcd_link_if));
  shcd_device #(.MEM_BYTES(1024)) u_shcd_device (.pclk(pclk), .presetn(presetn), .link(u_shcd_link_if),
    .radio_busy(radio_busy), .radio_write_event(ev[3]), .radio_read_event(ev[2]),
    .radio_transmit_event(ev[1]), .field_detect_event(ev[0]), .config_enable_check(cfg_err),
    .block_check_character(bcc_err), .irq_mask(irq_mask), .radio_stop(radio_stop),
    .self_reset_req(self_reset_req));
  shcd_link_assertions u_shcd_link_assertions (.pclk(pclk), .presetn(presetn),
    .wr_valid(u_shcd_link_if.wr_valid), .wr_data(u_shcd_link_if.wr_data), .wr_end(u_shcd_link_if.wr_end),
    .rd_req(u_shcd_link_if.rd_req), .rsp_valid(u_shcd_link_if.rsp_valid), .rsp_data(u_shcd_link_if.rsp_data),
    .rsp_last(u_shcd_link_if.rsp_last), .rd_end(u_shcd_link_if.rd_end));

  ////////////////////////////////////////////////////////////
  // Clock and self reset pulse count
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (self_reset_req === 1'b1) srst_count++;
  end

  // One APB transfer; waits for pready, result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task tx(input logic [7:0] b, input logic stop);
    apb(1'b1, `SHCD_REG_TX, {23'h0, stop, b});
  endtask : tx

  // Right-justified bytes, first byte highest; stop after the last
  task cmd(input logic [47:0] b, input int n);
    for (int j = 0; j < n; j++) tx(b[8 * (n - 1 - j) +: 8], j == n - 1);
  endtask : cmd

  task chk(input string nm, input logic [8:0] ex, input logic [8:0] got);
    cmp_count++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Answer byte as {last, data}
  task rx(input string nm, input logic [8:0] ex);
    apb(1'b0, `SHCD_REG_RX, 32'h0);
    chk(nm, ex, q[8:0]);
  endtask : rx

  task fin;
    apb(1'b1, `SHCD_REG_END, 32'h0);
  endtask : fin

  task ans1(input string nm, input logic [7:0] st);
    rx(nm, {1'b1, st});
    fin;
  endtask : ans1

  task pulse(input int n);
    @(posedge pclk);
    ev <= 4'(1 << n);
    @(posedge pclk);
    ev <= 4'h0;
  endtask : pulse

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    give_verdict;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, radio_busy, bcc_err} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 4'h0;
    cfg_err = 1'b1;
    tbl = '{12'h289, 12'h389, 12'h558, 12'h008};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    ans1("idle_poll", 8'h00);
    // Each event flag shows once, then the status read clears it
    for (i = 0; i < 4; i++) begin
      pulse(i);
      ans1("event_flag", {4'(1 << i), 4'h0});
      ans1("flag_cleared", 8'h00);
    end
    // Masked event must not raise its flag
    cmd(48'h7880, 2);
    ans1("ctrl_write", 8'h05);
    chk("irq_mask", 9'h008, {5'h0, irq_mask});
    pulse(3);
    ans1("masked_poll", 8'h00);
    // Control settings echoed with live check bits
    cmd(48'h78F8, 2);
    ans1("ctrl_write", 8'h05);
    chk("radio_stop", 9'h001, {8'h0, radio_stop});
    cmd(48'h68, 1);
    rx("rb_status", {1'b0, 8'h05});
    rx("rb_data", {1'b1, 8'hFE});
    fin;
    cfg_err <= 1'b0;
    bcc_err <= 1'b1;
    cmd(48'h7850, 2);
    ans1("ctrl_write", 8'h05);
    cmd(48'h68, 1);
    rx("rb_status", {1'b0, 8'h05});
    rx("rb_data", {1'b1, 8'h55});
    fin;
    // Memory write, then read back two bytes
    cmd(48'h180010_02A53C, 6);
    ans1("mem_write", 8'h05);
    cmd(48'h08001002, 4);
    rx("rd_status", {1'b0, 8'h05});
    rx("rd_data0", {1'b0, 8'hA5});
    rx("rd_data1", {1'b1, 8'h3C});
    fin;
    cmd(48'h0803FF02, 4);
    ans1("rd_range", 8'h0A);
    // Zero length refused by the host, command then completed
    tx(8'h08, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h10, 1'b0);
    tx(8'h00, 1'b0);
    chk("len_refused", 9'h001, {8'h0, e});
    apb(1'b0, `SHCD_REG_STAT, 32'h0);
    chk("len_flag", 9'h001, {8'h0, q[0]});
    apb(1'b1, `SHCD_REG_STAT, 32'h1);
    apb(1'b0, `SHCD_REG_STAT, 32'h0);
    chk("len_flag_clr", 9'h000, {8'h0, q[0]});
    tx(8'h01, 1'b1);
    rx("div_status", {1'b0, 8'h05});
    rx("div_data", {1'b1, 8'hA5});
    fin;
    // Radio busy: read, write, poll busy; readback normal; control refused
    radio_busy <= 1'b1;
    ans1("busy_poll", 8'h07);
    cmd(48'h08001001, 4);
    ans1("busy_read", 8'h07);
    cmd(48'h18001001_77, 5);
    ans1("busy_write", 8'h07);
    cmd(48'h68, 1);
    rx("busy_rb", {1'b0, 8'h05});
    rx("busy_rb_data", {1'b1, 8'h55});
    fin;
    cmd(48'h7880, 2);
    ans1("busy_ctrl", 8'h0A);
    chk("irq_kept", 9'h005, {5'h0, irq_mask});
    radio_busy <= 1'b0;
    cmd(48'h08001001, 4);
    rx("mem_kept", {1'b0, 8'h05});
    rx("mem_kept_data", {1'b1, 8'hA5});
    fin;
    // Tunnel and unknown codes
    for (i = 0; i < 4; i++) begin
      cmd({40'h0, tbl[i][11:4]}, 1);
      ans1("code_result", {4'h0, tbl[i][3:0]});
    end
    // Self reset request after the answer is closed
    cmd(48'h7801, 2);
    ans1("ctrl_reset", 8'h05);
    repeat (4) @(posedge pclk);
    chk("self_reset", 9'h001, 9'(srst_count));
    give_verdict;
  end
endmodule : serial_host_command_decoder_tb
